// file: design/scc_clock_ctrl.sv
// system clock selection, module clock gating and audio clock dividers
// assumes source clocks arrive as pins far slower than clk_i and a wishbone master
`timescale 1ns/1ps

// Function
// (RULE_01) four system clock sources: rc_osc_clock, fast, divided fast, 32M from 48M
// (RULE_02) select register bits 6:5 choose the system clock source
// (RULE_03) source code 00 rc, 01 fast, 10 divided fast, 11 32M
// (RULE_04) fast clock chosen by fast select bit 0 and select register bit 7
// (RULE_05) fast code 00 doubled 48M, 01 rc_osc_clock, 1x crystal 24M
// (RULE_06) source 10 gives fast clock divided by select register bits 4:0
// (RULE_07) software never writes divider value 0 or 1
// (RULE_08) three module gate registers at 0x63 to 0x65 gate module clocks
// (RULE_09) gate bit one runs the module clock, zero stops it
// (RULE_10) timer clock is crystal clock times two thirds, fixed 16M
// (RULE_11) usb clock is the 48M doubled crystal clock directly
// (RULE_12) serial audio clock runs only while 0x67 bit 7 is one
// (RULE_13) serial audio clock is 48M times step over mod, 0x67 and 0x68
// (RULE_14) software keeps serial audio mod at least twice its step
// (RULE_15) codec clock enabled by 0x6c bit 7, stopped while zero
// (RULE_16) codec clock is 48M times step over mod, 0x6c and 0x6d
// (RULE_17) software keeps codec_divider_modulus at least twice its step
// (RULE_18) source or divider change never makes a runt system clock pulse
// (RULE_19) fractional dividers accumulate step modulo mod per 48M edge
module scc_clock_ctrl (
  input wire logic clk_i,  // core clock, 125 MHz
  input wire logic rst_i,  // synchronous reset, active high
  input wire logic wb_cyc_i,  // wishbone cycle
  input wire logic wb_stb_i,  // wishbone strobe
  input wire logic wb_we_i,  // wishbone write enable
  input wire logic [9:0] wb_adr_i,  // wishbone byte address
  input wire logic [3:0] wb_sel_i,  // wishbone byte selects
  input wire logic [31:0] wb_dat_i,  // wishbone write data
  output logic [31:0] wb_dat_o,  // wishbone read data
  output logic wb_ack_o,  // wishbone acknowledge
  input wire logic rc_osc_clock_i,  // rc oscillator 24M pin
  input wire logic crystal_clock_i,  // crystal 24M pin
  input wire logic doubled_clock_i,  // doubled crystal 48M pin
  output logic sys_clock_o,  // system clock
  output logic [23:0] module_clock_o,  // gated module clocks
  output logic timer_clock_o,  // system timer clock 16M
  output logic usb_clock_o,  // usb clock 48M
  output logic i2s_clock_o,  // serial audio clock
  output logic codec_clock_o  // codec clock
);

  // ---------------- registers ----------------
  logic [7:0] module_gate_reg_a;
  logic [7:0] module_gate_reg_b;
  logic [7:0] module_gate_reg_c;
  logic [7:0] system_clock_select_reg;
  logic [7:0] i2s_step_r;
  logic [7:0] i2s_mod_r;
  logic [7:0] codec_divider_step_r;
  logic [7:0] codec_divider_modulus_r;
  logic [7:0] fast_clock_select_r;

  logic [7:0] idx;
  logic req;
  logic wr;
  logic [7:0] rd_nxt;

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      module_gate_reg_a <= scc_pkg::RST_GATE_A;
      module_gate_reg_b <= scc_pkg::RST_GATE_B;
      module_gate_reg_c <= scc_pkg::RST_GATE_C;
      system_clock_select_reg <= scc_pkg::RST_SYS_SEL;
      i2s_step_r <= scc_pkg::RST_I2S_STEP;
      i2s_mod_r <= scc_pkg::RST_I2S_MOD;
      codec_divider_step_r <= scc_pkg::RST_CODEC_DIVIDER_STEP;
      codec_divider_modulus_r <= scc_pkg::RST_CODEC_DIVIDER_MODULUS;
      fast_clock_select_r <= scc_pkg::RST_FAST_SEL;
    end else if (wr) begin
      case (idx)
        scc_pkg::IDX_GATE_A: module_gate_reg_a <= wb_dat_i[7:0];  // RULE_08
        scc_pkg::IDX_GATE_B: module_gate_reg_b <= wb_dat_i[7:0];  // RULE_08
        scc_pkg::IDX_GATE_C: module_gate_reg_c <= wb_dat_i[7:0];  // RULE_08
        scc_pkg::IDX_SYS_SEL: system_clock_select_reg <= wb_dat_i[7:0];  // RULE_02
        scc_pkg::IDX_I2S_STEP: i2s_step_r <= wb_dat_i[7:0];
        scc_pkg::IDX_I2S_MOD: i2s_mod_r <= wb_dat_i[7:0];
        scc_pkg::IDX_CODEC_DIVIDER_STEP: codec_divider_step_r <= wb_dat_i[7:0];
        scc_pkg::IDX_CODEC_DIVIDER_MODULUS: codec_divider_modulus_r <= wb_dat_i[7:0];
        scc_pkg::IDX_FAST_SEL: fast_clock_select_r <= wb_dat_i[7:0];
        default: begin
        end
      endcase
    end
  end

  // ---------------- source pin synchronisers ----------------
  logic [2:0] pin_in;
  logic [2:0] edge_tick;

  assign pin_in[scc_pkg::PIN_RC] = rc_osc_clock_i;
  assign pin_in[scc_pkg::PIN_XTAL] = crystal_clock_i;
  assign pin_in[scc_pkg::PIN_DBL] = doubled_clock_i;

  genvar g;
  generate
    for (g = 0; g < scc_pkg::NSRC; g = g + 1) begin : g_sync
      logic meta_r;
      logic sync_r;
      logic last_r;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          last_r <= 1'b0;
        end else begin
          meta_r <= pin_in[g];
          sync_r <= meta_r;
          last_r <= sync_r;
        end
      end
      // one pulse per source edge, rising or falling
      assign edge_tick[g] = sync_r ^ last_r;
    end
  endgenerate

  logic rc_tick;
  logic xtal_tick;
  logic dbl_tick;
  assign rc_tick = edge_tick[scc_pkg::PIN_RC];
  assign xtal_tick = edge_tick[scc_pkg::PIN_XTAL];
  assign dbl_tick = edge_tick[scc_pkg::PIN_DBL];

  // ---------------- two-thirds dividers: 48M to 32M, crystal to 16M ----------------
  logic [1:0] third_in;
  logic [1:0] third_tick;
  logic [1:0] third_clk;

  assign third_in[0] = dbl_tick;  // RULE_01
  assign third_in[1] = xtal_tick;  // RULE_10

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_third
      logic [1:0] cnt_r;
      logic lvl_r;
      // toggle on two of every three source edges
      assign third_tick[g] = third_in[g] && (cnt_r != 2'h2);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_r <= 2'h0;
        end else if (third_in[g]) begin
          cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          lvl_r <= 1'b0;
        end else if (third_tick[g]) begin
          lvl_r <= ~lvl_r;
        end
      end
      assign third_clk[g] = lvl_r;
    end
  endgenerate

  assign timer_clock_o = third_clk[1];  // RULE_10

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      usb_clock_o <= 1'b0;
    end else begin
      usb_clock_o <= g_sync[scc_pkg::PIN_DBL].sync_r;  // RULE_11
    end
  end

  // ---------------- system clock switch ----------------
  logic [1:0] req_src;
  logic [1:0] req_fsel;
  logic [4:0] req_div;
  logic [1:0] act_src_r;
  logic [1:0] act_fsel_r;
  logic [4:0] act_div_r;
  logic [4:0] div_cnt_r;
  logic [4:0] div_eff;
  logic fast_tick;
  logic div_tick;
  logic sel_tick;
  logic pending;
  logic load;
  logic sys_clk_r;
  logic sys_clk_nxt;
  scc_pkg::scc_sw_e sw_r;
  scc_pkg::scc_sw_e sw_nxt;

  assign req_src = system_clock_select_reg[scc_pkg::SYS_SRC_LSB +: 2];  // RULE_02
  assign req_fsel = {fast_clock_select_r[scc_pkg::FAST_SEL_BIT],
                     system_clock_select_reg[scc_pkg::SYS_FSEL_BIT]};  // RULE_04
  assign req_div = system_clock_select_reg[scc_pkg::SYS_DIV_LSB +: scc_pkg::SYS_DIV_W];
  assign pending = (req_src != act_src_r) || (req_fsel != act_fsel_r) ||
                   (req_div != act_div_r);

  // a divider of 0 or 1 is illegal; it is run as the smallest legal value
  assign div_eff = (act_div_r < scc_pkg::DIV_MIN) ? scc_pkg::DIV_MIN : act_div_r;  // RULE_07

  always_comb begin
    case (act_fsel_r)
      scc_pkg::FSEL_DBL: fast_tick = dbl_tick;  // RULE_05
      scc_pkg::FSEL_RC: fast_tick = rc_tick;  // RULE_05
      default: fast_tick = xtal_tick;  // RULE_05
    endcase
  end

  // toggling every div edges gives the fast frequency over div
  assign div_tick = fast_tick && (div_cnt_r == div_eff - 5'h01);  // RULE_06

  always_comb begin
    case (act_src_r)
      scc_pkg::SRC_RC: sel_tick = rc_tick;  // RULE_03
      scc_pkg::SRC_FAST: sel_tick = fast_tick;  // RULE_03
      scc_pkg::SRC_DIV: sel_tick = div_tick;  // RULE_03
      default: sel_tick = third_tick[0];  // RULE_03
    endcase
  end

  // change sources only while low, then discard the first new edge
  always_comb begin
    sw_nxt = sw_r;
    load = 1'b0;
    sys_clk_nxt = sys_clk_r;
    case (sw_r)
      scc_pkg::SW_RUN: begin
        if (pending && !sys_clk_r) begin
          load = 1'b1;  // RULE_18
          sw_nxt = scc_pkg::SW_SKIP;
        end else if (pending) begin
          sw_nxt = scc_pkg::SW_PARK;
        end else if (sel_tick) begin
          sys_clk_nxt = ~sys_clk_r;
        end
      end
      scc_pkg::SW_PARK: begin
        if (sel_tick) begin
          sys_clk_nxt = 1'b0;  // RULE_18
          load = 1'b1;
          sw_nxt = scc_pkg::SW_SKIP;
        end
      end
      scc_pkg::SW_SKIP: begin
        if (sel_tick) begin
          sw_nxt = scc_pkg::SW_RUN;  // RULE_18
        end
      end
      default: sw_nxt = scc_pkg::SW_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_r <= scc_pkg::SW_SKIP;
    end else begin
      sw_r <= sw_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_clk_r <= 1'b0;
    end else begin
      sys_clk_r <= sys_clk_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_src_r <= scc_pkg::RST_SYS_SEL[scc_pkg::SYS_SRC_LSB +: 2];
      act_fsel_r <= {scc_pkg::RST_FAST_SEL[scc_pkg::FAST_SEL_BIT],
                     scc_pkg::RST_SYS_SEL[scc_pkg::SYS_FSEL_BIT]};
      act_div_r <= scc_pkg::RST_SYS_SEL[scc_pkg::SYS_DIV_LSB +: scc_pkg::SYS_DIV_W];
    end else if (load) begin
      act_src_r <= req_src;  // RULE_18
      act_fsel_r <= req_fsel;
      act_div_r <= req_div;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_r <= 5'h00;
    end else if (load) begin
      div_cnt_r <= 5'h00;
    end else if (div_tick) begin
      div_cnt_r <= 5'h00;
    end else if (fast_tick) begin
      div_cnt_r <= div_cnt_r + 5'h01;  // RULE_06
    end
  end

  assign sys_clock_o = sys_clk_r;  // RULE_01

  // ---------------- module clock gates ----------------
  logic [23:0] gate_en;
  assign gate_en = {module_gate_reg_c, module_gate_reg_b, module_gate_reg_a};

  generate
    for (g = 0; g < scc_pkg::NGATE; g = g + 1) begin : g_gate
      logic live_r;
      logic live_nxt;
      // the enable is only taken while the clock is low, so no runt pulses
      assign live_nxt = sys_clk_r ? live_r : gate_en[g];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          live_r <= 1'b0;
          module_clock_o[g] <= 1'b0;
        end else begin
          live_r <= live_nxt;  // RULE_08
          module_clock_o[g] <= sys_clk_nxt & live_nxt;  // RULE_09
        end
      end
    end
  endgenerate

  // ---------------- fractional audio dividers ----------------
  scc_frac_div u_i2s_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(dbl_tick),
    .en_i(i2s_step_r[scc_pkg::FRAC_EN_BIT]),  // RULE_12
    .step_i(i2s_step_r[scc_pkg::FRAC_STEP_W-1:0]),  // RULE_13
    .mod_i(i2s_mod_r),  // RULE_13
    .clk_o(i2s_clock_o)
  );

  scc_frac_div u_codec_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(dbl_tick),
    .en_i(codec_divider_step_r[scc_pkg::FRAC_EN_BIT]),  // RULE_15
    .step_i(codec_divider_step_r[scc_pkg::FRAC_STEP_W-1:0]),  // RULE_16
    .mod_i(codec_divider_modulus_r),  // RULE_16
    .clk_o(codec_clock_o)
  );

  // ---------------- read path ----------------
  always_comb begin
    case (idx)
      scc_pkg::IDX_GATE_A: rd_nxt = module_gate_reg_a;
      scc_pkg::IDX_GATE_B: rd_nxt = module_gate_reg_b;
      scc_pkg::IDX_GATE_C: rd_nxt = module_gate_reg_c;
      scc_pkg::IDX_SYS_SEL: rd_nxt = system_clock_select_reg;
      scc_pkg::IDX_I2S_STEP: rd_nxt = i2s_step_r;
      scc_pkg::IDX_I2S_MOD: rd_nxt = i2s_mod_r;
      scc_pkg::IDX_CODEC_DIVIDER_STEP: rd_nxt = codec_divider_step_r;
      scc_pkg::IDX_CODEC_DIVIDER_MODULUS: rd_nxt = codec_divider_modulus_r;
      scc_pkg::IDX_FAST_SEL: rd_nxt = fast_clock_select_r;
      scc_pkg::IDX_STATUS: rd_nxt = {2'h0, sys_clk_r, (sw_r != scc_pkg::SW_RUN),
                                     act_fsel_r, act_src_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h00000000;
    end else if (req) begin
      wb_dat_o <= {24'h000000, rd_nxt};
    end
  end

endmodule // scc_clock_ctrl

// file: design/scc_frac_div.sv
// fractional step/mod clock divider
// assumes tick_i marks every edge of the 48 MHz source, sampled on clk_i
`timescale 1ns/1ps
module scc_frac_div (
  input wire logic clk_i,  // core clock
  input wire logic rst_i,  // synchronous reset, active high
  input wire logic tick_i,  // one pulse per source edge
  input wire logic en_i,  // divider enable
  input wire logic [6:0] step_i,  // step value
  input wire logic [7:0] mod_i,  // modulus value
  output logic clk_o  // divided clock level
);

  logic [8:0] acc_r;
  logic [8:0] acc_nxt;
  logic wrap;

  // two source edges per period, so a toggle per wrap gives 48M*step/mod
  always_comb begin
    acc_nxt = acc_r + {2'h0, step_i};
    wrap = (mod_i != 8'h00) && (acc_nxt >= {1'b0, mod_i});
    if (wrap) begin
      acc_nxt = acc_nxt - {1'b0, mod_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_r <= 9'h000;
    end else if (!en_i) begin
      acc_r <= 9'h000;
    end else if (tick_i) begin
      acc_r <= acc_nxt;  // RULE_19
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_o <= 1'b0;
    end else if (!en_i) begin
      clk_o <= 1'b0;
    end else if (tick_i && wrap) begin
      clk_o <= ~clk_o;
    end
  end

endmodule // scc_frac_div

// file: design/scc_pkg.sv
// constants shared by the system and module clock controller
// assumes a classic wishbone slave with 32-bit data, word index = byte address / 4
package scc_pkg;

  // register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_GATE_A = 8'h63;
  localparam logic [7:0] IDX_GATE_B = 8'h64;
  localparam logic [7:0] IDX_GATE_C = 8'h65;
  localparam logic [7:0] IDX_SYS_SEL = 8'h66;
  localparam logic [7:0] IDX_I2S_STEP = 8'h67;
  localparam logic [7:0] IDX_I2S_MOD = 8'h68;
  localparam logic [7:0] IDX_CODEC_DIVIDER_STEP = 8'h6c;
  localparam logic [7:0] IDX_CODEC_DIVIDER_MODULUS = 8'h6d;
  localparam logic [7:0] IDX_FAST_SEL = 8'h70;
  localparam logic [7:0] IDX_STATUS = 8'h71;

  // reset values
  localparam logic [7:0] RST_GATE_A = 8'h83;
  localparam logic [7:0] RST_GATE_B = 8'h00;
  localparam logic [7:0] RST_GATE_C = 8'h30;
  localparam logic [7:0] RST_SYS_SEL = 8'h06;
  localparam logic [7:0] RST_I2S_STEP = 8'h00;
  localparam logic [7:0] RST_I2S_MOD = 8'h02;
  localparam logic [7:0] RST_CODEC_DIVIDER_STEP = 8'h01;
  localparam logic [7:0] RST_CODEC_DIVIDER_MODULUS = 8'h02;
  localparam logic [7:0] RST_FAST_SEL = 8'h00;

  // field positions
  localparam int SYS_DIV_LSB = 0;
  localparam int SYS_DIV_W = 5;
  localparam int SYS_SRC_LSB = 5;
  localparam int SYS_FSEL_BIT = 7;
  localparam int FAST_SEL_BIT = 0;
  localparam int FRAC_EN_BIT = 7;
  localparam int FRAC_STEP_W = 7;
  localparam int FRAC_MOD_W = 8;

  // system clock source field encoding
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_FAST = 2'h1;
  localparam logic [1:0] SRC_DIV = 2'h2;
  localparam logic [1:0] SRC_32M = 2'h3;

  // fast clock select encoding {fast_sel[0], sys_sel[7]}
  localparam logic [1:0] FSEL_DBL = 2'h0;
  localparam logic [1:0] FSEL_RC = 2'h1;

  // smallest legal divider value
  localparam logic [4:0] DIV_MIN = 5'h02;

  // source clock pins, index into the synchroniser bank
  localparam int NSRC = 3;
  localparam int PIN_RC = 0;
  localparam int PIN_XTAL = 1;
  localparam int PIN_DBL = 2;

  localparam int NGATE = 24;

  typedef enum logic [1:0] {
    SW_RUN,
    SW_PARK,
    SW_SKIP
  } scc_sw_e;

endpackage

// file: tb/scc_clock_ctrl_bench.sv
// testbench for the clock controller: register access and output edge counts
// assumes slow source stand-ins: rc edge every 5 cycles, crystal 6, doubled 3
`timescale 1ns/1ps
module scc_clock_ctrl_bench;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic rc_osc_clock_i = 1'b0, crystal_clock_i = 1'b0, doubled_clock_i = 1'b0;
  logic sys_clock_o, timer_clock_o, usb_clock_o, i2s_clock_o, codec_clock_o;
  logic [23:0] module_clock_o;
  int n_mismatch = 0, checks_done = 0, cycles = 0, pin_cnt = 0;
  int cnt [8];
  localparam int LIMIT = 20000;
  localparam logic [7:0] IDX_TAB [9] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h6c,
    8'h6d, 8'h70};
  localparam logic [7:0] RST_TAB [9] = '{8'h83, 8'h00, 8'h30, 8'h06, 8'h00, 8'h02, 8'h01,
    8'h02, 8'h00};
  // system select, fast select and expected system clock edges in 360 cycles
  // every value keeps the divider field at two or more, even when unused
  localparam logic [7:0] SYS_V [10] = '{8'h22, 8'ha2, 8'h22, 8'ha2, 8'h42, 8'h45, 8'h5f,
    8'h62, 8'h62, 8'h06};
  localparam logic [7:0] FAST_V [10] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h01, 8'h00};
  localparam int SYS_EXP [10] = '{120, 72, 60, 60, 60, 24, 3, 80, 80, 72};
  scc_clock_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rc_osc_clock_i(rc_osc_clock_i),
    .crystal_clock_i(crystal_clock_i), .doubled_clock_i(doubled_clock_i),
    .sys_clock_o(sys_clock_o), .module_clock_o(module_clock_o), .timer_clock_o(timer_clock_o),
    .usb_clock_o(usb_clock_o), .i2s_clock_o(i2s_clock_o), .codec_clock_o(codec_clock_o));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    pin_cnt <= pin_cnt + 1;
    if (pin_cnt % 5 == 4) rc_osc_clock_i <= ~rc_osc_clock_i;
    if (pin_cnt % 6 == 5) crystal_clock_i <= ~crystal_clock_i;
    if (pin_cnt % 3 == 2) doubled_clock_i <= ~doubled_clock_i;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      $display("BAD at %0t: run did not finish", $time);
      test_done();
    end
  end
  task automatic test_done();
    $display("counts: %0d mismatches in %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one classic cycle; ack is sampled on rising edges, release follows that edge
  task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= 4'hf;
    wb_dat_i <= {24'h0, wd};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    wb_xfer(1'b1, idx, wd);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    wb_xfer(1'b0, idx, 8'h00);
    checks_done++;
    if (rd !== {24'h0, exp}) begin
      n_mismatch++;
      $display("BAD at %0t: reg %h read %h want %h", $time, idx, rd, exp);
    end
  endtask
  task automatic near(input int got, input int exp, input string what);
    checks_done++;
    if (got < exp - 1 || got > exp + 1) begin
      n_mismatch++;
      $display("BAD at %0t: %s edges %0d want %0d", $time, what, got, exp);
    end
  endtask
  function automatic logic [7:0] outs();
    return {module_clock_o[0], module_clock_o[16], module_clock_o[8], codec_clock_o,
      i2s_clock_o, timer_clock_o, usb_clock_o, sys_clock_o};
  endfunction
  // settle after a switch, then count edges of every watched output over 360 cycles
  task automatic measure();
    logic [7:0] prev;
    logic [7:0] now;
    repeat (200) @(posedge clk_i);
    foreach (cnt[i]) cnt[i] = 0;
    @(negedge clk_i);
    prev = outs();
    repeat (360) begin
      @(negedge clk_i);
      now = outs();
      for (int i = 0; i < 8; i++) if (now[i] !== prev[i]) cnt[i]++;
      prev = now;
    end
    near(cnt[1], 120, "usb");
    near(cnt[2], 40, "timer");
  endtask
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) rd_chk(IDX_TAB[i], RST_TAB[i]);
    wr(8'h6a, 8'hff);
    rd_chk(8'h6a, 8'h00);
    measure();
    near(cnt[0], 72, "sys rc");
    near(cnt[7], 72, "gate a bit0");
    near(cnt[5], 0, "gate b bit0");
    near(cnt[3] + cnt[4], 0, "audio off");
    $display("test reset_values done");
    wr(8'h63, 8'h00);
    wr(8'h64, 8'h01);
    wr(8'h65, 8'h31);
    rd_chk(8'h65, 8'h31);
    measure();
    near(cnt[7], 0, "gate a stopped");
    near(cnt[5], 72, "gate b run");
    near(cnt[6], 72, "gate c run");
    $display("test module_gates done");
    for (int i = 0; i < 10; i++) begin
      wr(8'h70, FAST_V[i]);
      wr(8'h66, SYS_V[i]);
      rd_chk(8'h66, SYS_V[i]);
      measure();
      near(cnt[0], SYS_EXP[i], "sys");
    end
    $display("test system_select done");
    wr(8'h67, 8'h81);
    wr(8'h68, 8'h04);
    wr(8'h6c, 8'h82);
    wr(8'h6d, 8'h05);
    measure();
    near(cnt[3], 30, "i2s 1/4");
    near(cnt[4], 48, "codec 2/5");
    wr(8'h67, 8'h83);
    wr(8'h68, 8'h08);
    wr(8'h6d, 8'h04);
    measure();
    near(cnt[3], 45, "i2s 3/8");
    near(cnt[4], 60, "codec 2/4");
    wr(8'h67, 8'h03);
    wr(8'h6c, 8'h02);
    measure();
    near(cnt[3], 0, "i2s off");
    near(cnt[4], 0, "codec off");
    $display("test audio_dividers done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(8'h67, 8'h00);
    rd_chk(8'h65, 8'h30);
    $display("test second_reset done");
    test_done();
  end
endmodule // scc_clock_ctrl_bench

// file: tb/scc_clock_ctrl_sva.sv
// checker for the clock controller: bus handshake and clock output timing
// assumes source pins toggle no faster than every third core clock
`timescale 1ns/1ps
module scc_clock_ctrl_sva (
  input wire logic clk_i,  // core clock
  input wire logic rst_i,  // synchronous reset
  input wire logic wb_cyc_i,  // wishbone cycle
  input wire logic wb_stb_i,  // wishbone strobe
  input wire logic [31:0] wb_dat_o,  // read data
  input wire logic wb_ack_o,  // acknowledge
  input wire logic crystal_clock_i,  // crystal pin
  input wire logic doubled_clock_i,  // doubled pin
  input wire logic sys_clock_o,  // system clock
  input wire logic timer_clock_o,  // timer clock
  input wire logic usb_clock_o  // usb clock
);
  logic [6:0] xtal_hist_r;
  logic [2:0] since_rst_r;
  always_ff @(posedge clk_i) begin
    xtal_hist_r <= {xtal_hist_r[5:0], crystal_clock_i};
  end
  // the pin synchroniser needs a few cycles to refill after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) since_rst_r <= 3'h0;
    else if (since_rst_r != 3'h7) since_rst_r <= since_rst_r + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_answer;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("ack missing after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    $rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_upper;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
  endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("read data upper bits set");
  property p_reset_quiet;
    $fell(rst_i) |-> !wb_ack_o && !sys_clock_o && !usb_clock_o && !timer_clock_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  property p_sys_no_runt;
    $changed(sys_clock_o) |=> $stable(sys_clock_o)[*2];
  endproperty
  a_sys_no_runt: assert property (p_sys_no_runt) else $error("runt system clock phase");
  property p_usb_follow;
    since_rst_r == 3'h7 |-> usb_clock_o == $past(doubled_clock_i, 3);
  endproperty
  a_usb_follow: assert property (p_usb_follow) else $error("usb clock not the 48M pin");
  property p_timer_edge;
    $changed(timer_clock_o) |-> xtal_hist_r[6:1] != xtal_hist_r[5:0];
  endproperty
  a_timer_edge: assert property (p_timer_edge) else $error("timer edge without crystal edge");
endmodule // scc_clock_ctrl_sva

bind scc_clock_ctrl scc_clock_ctrl_sva u_sva (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .crystal_clock_i(crystal_clock_i),
  .doubled_clock_i(doubled_clock_i),
  .sys_clock_o(sys_clock_o),
  .timer_clock_o(timer_clock_o),
  .usb_clock_o(usb_clock_o)
);
